/* File: include/sra_defines.svh */
/*
 * Constants of the serial register access port: register offsets, field
 * positions, reset values and serial framing counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SRA_DEFINES_SVH
`define SRA_DEFINES_SVH

`define SRA_REG_NUM 128
`define SRA_BIT_LAST 3'h7
`define SRA_CRC_POLY 8'h07
`define SRA_CRC_SEED 8'ha5
`define SRA_LOCK_LAST 5'h17
`define SRA_ONES_MAX 5'h18
`define SRA_PKT_LAST 5'h17
`define SRA_REG_IFCFG 7'h00
`define SRA_SINGLE_BIT 0
`define SRA_IFCFG_RST 8'h01
`define SRA_REG_STREAM 7'h0e
`define SRA_REG_XFER 7'h0f
`define SRA_XFER_BIT 0
`define SRA_STAGE_LO 7'h30
`define SRA_STAGE_N 8
`define SRA_STAGE_HI 7'h37

`endif

/* File: include/sra_pkg.sv */
/*
 * Types of the serial register access port.
 * Assumes nothing of its surroundings.
 */
package sra_pkg;

    typedef enum logic [1:0] {
        PH_CMD,
        PH_DATA,
        PH_CRC
    } sra_phase_type;

endpackage

/* File: rtl/sra_top.sv */
/*
 * Serial register access port: mode-0 serial slave with 7-bit addressing,
 * 3-wire, 4-wire and isolated 3-wire framing, CRC-8, streaming, single
 * transaction mode, staged commit and lock/unlock recovery.
 * Assumes the host drives the serial clock on i_sclk, keeps it low when
 * idle, and ties chip select low while it uses the isolated mode.
 */
// Overview of operation
// - Port active only when mode select high.
// - Drive on falling edge, sample on rising.
// - Command carries a 7-bit register address.
// - Supports 3-wire, 4-wire and minimum I/O wiring.
// - 3-wire: output pin idle, data on input.
// - CRC-8 polynomial 0x07, seed 0xa5.
// - Power up isolated; chip select toggle exits.
// - Isolated packet: command, data, CRC bytes.
// - No streaming in isolated mode.
// - Single flag: one access per instruction.
// - Single flag: new instruction after data byte, or after the CRC byte when CRC is on.
// - Single flag resets to set.
// - Twenty-four ones lock register access.
// - Twenty-three ones then zero unlock, reset.
// - Locking leaves output pin behaviour unchanged.
// - Stream count sets wrap length; zero disables.
// - Transfer bit commits staged bytes, self-clears.
`timescale 1ns/1ps
`include "sra_defines.svh"

module sra_top (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire logic i_spi_sel,
    input wire logic i_three_wire,
    input wire logic i_crc_en,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_sdi_out,
    output logic o_sdi_oe,
    output logic o_locked,
    output logic o_isolated,
    output logic o_commit,
    output logic o_crc_err
);
    import sra_pkg::*;

    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic b);
        return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `SRA_CRC_POLY : 8'h00);
    endfunction

    // ==========================================================
    // Reference clock domain.
    logic cs_meta_q, cs_sync_q, iso_q;
    logic [2:0] ev_meta_q, ev_sync_q, ev_last_q;
    logic lock_meta_q, lock_sync_q, commit_q, crc_err_q;
    logic lock_q, commit_tgl_q, err_tgl_q;

    always_ff @(posedge i_ref_clk) begin
        cs_meta_q <= i_cs_n;
        cs_sync_q <= cs_meta_q;
        ev_meta_q <= {lock_q, commit_tgl_q, err_tgl_q};
        ev_sync_q <= ev_meta_q;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            iso_q <= 1'b1;
        end else if (cs_sync_q) begin
            iso_q <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ev_last_q <= 3'h0;
            lock_sync_q <= 1'b0;
            commit_q <= 1'b0;
            crc_err_q <= 1'b0;
        end else begin
            ev_last_q <= ev_sync_q;
            lock_sync_q <= ev_sync_q[2];
            commit_q <= ev_sync_q[1] ^ ev_last_q[1];
            crc_err_q <= ev_sync_q[0] ^ ev_last_q[0];
        end
    end

    assign o_isolated = iso_q;
    assign o_locked = lock_sync_q;
    assign o_commit = commit_q;
    assign o_crc_err = crc_err_q;

    a_iso_powerup: assert property (@(posedge i_ref_clk)
        !i_rst_n |=> iso_q) else $error("isolated mode not set");

    // ==========================================================
    // Serial clock domain: level crossings in.
    logic [4:0] s_meta_q, s_sync_q;
    logic srst, iso, sel, tw, crc_on;

    always_ff @(posedge i_sclk) begin
        s_meta_q <= {i_rst_n, iso_q, i_spi_sel, i_three_wire, i_crc_en};
        s_sync_q <= s_meta_q;
    end

    assign srst = !s_sync_q[4];
    assign iso = s_sync_q[3];
    assign sel = s_sync_q[2];
    assign tw = s_sync_q[1];
    assign crc_on = s_sync_q[0] | iso;

    // ==========================================================
    // Command framing.
    sra_phase_type phase_q;
    logic [2:0] bit_q;
    logic rd_q;
    logic [6:0] addr_q, base_q;
    logic [7:0] cnt_q, sh_q, pdata_q, tx_q, crc_q;
    logic [4:0] ones_q;
    logic [7:0] regs_q [0:`SRA_REG_NUM-1];
    logic [7:0] shadow_q [0:`SRA_STAGE_N-1];

    logic [7:0] byte_w, crc_d, stream_cnt, wr_data;
    logic in_bit, last_bit, single, stream_on, wrap, lock_hit, unlock_hit;
    logic wr_fire, crc_bad, in_stage;
    logic [6:0] next_addr;

    assign byte_w = {sh_q[6:0], i_sdi};
    assign last_bit = sel && (bit_q == `SRA_BIT_LAST);
    assign in_bit = (rd_q && phase_q != PH_CMD) ? tx_q[~bit_q] : i_sdi;
    assign crc_d = crc_step(crc_q, in_bit);
    assign single = regs_q[`SRA_REG_IFCFG][`SRA_SINGLE_BIT];
    assign stream_cnt = regs_q[`SRA_REG_STREAM];
    assign stream_on = !single && !iso && (stream_cnt != 8'h00);
    assign wrap = (8'(cnt_q + 8'h01) == stream_cnt);
    assign next_addr = wrap ? base_q : 7'(addr_q + 7'h01);
    assign lock_hit = sel && (ones_q == `SRA_LOCK_LAST) && i_sdi;
    assign unlock_hit = sel && (ones_q == `SRA_LOCK_LAST) && !i_sdi;

    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            phase_q <= PH_CMD;
            bit_q <= 3'h0;
            rd_q <= 1'b0;
            addr_q <= 7'h00;
            base_q <= 7'h00;
            cnt_q <= 8'h00;
            sh_q <= 8'h00;
            pdata_q <= 8'h00;
            tx_q <= 8'h00;
            crc_q <= `SRA_CRC_SEED;
        end else if (srst || unlock_hit) begin
            phase_q <= PH_CMD;
            bit_q <= 3'h0;
            rd_q <= 1'b0;
            crc_q <= `SRA_CRC_SEED;
        end else if (sel) begin
            bit_q <= 3'(bit_q + 3'h1);
            sh_q <= byte_w;
            if (phase_q != PH_CRC) begin
                crc_q <= crc_d;
            end
            if (last_bit) begin
                case (phase_q)
                    PH_CMD: begin
                        rd_q <= byte_w[7];
                        addr_q <= byte_w[6:0];
                        base_q <= byte_w[6:0];
                        cnt_q <= 8'h00;
                        phase_q <= PH_DATA;
                        tx_q <= lock_q ? 8'h00 : regs_q[byte_w[6:0]];
                    end
                    PH_DATA: begin
                        pdata_q <= byte_w;
                        if (crc_on) begin
                            phase_q <= PH_CRC;
                            tx_q <= crc_d;
                        end else if (stream_on) begin
                            addr_q <= next_addr;
                            cnt_q <= wrap ? 8'h00 : 8'(cnt_q + 8'h01);
                            tx_q <= lock_q ? 8'h00 : regs_q[next_addr];
                        end else begin
                            phase_q <= PH_CMD;
                            crc_q <= `SRA_CRC_SEED;
                        end
                    end
                    PH_CRC: begin
                        crc_q <= `SRA_CRC_SEED;
                        if (stream_on) begin
                            phase_q <= PH_DATA;
                            addr_q <= next_addr;
                            cnt_q <= wrap ? 8'h00 : 8'(cnt_q + 8'h01);
                            tx_q <= lock_q ? 8'h00 : regs_q[next_addr];
                        end else begin
                            phase_q <= PH_CMD;
                        end
                    end
                    default: begin
                        phase_q <= PH_CMD;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Lock and unlock detection.
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            ones_q <= 5'h00;
        end else if (srst || lock_hit || (sel && !i_sdi)) begin
            ones_q <= 5'h00;
        end else if (sel && ones_q != `SRA_ONES_MAX) begin
            ones_q <= 5'(ones_q + 5'h01);
        end
    end

    always_ff @(posedge i_sclk) begin
        if (srst) begin
            lock_q <= 1'b0;
        end else if (lock_hit) begin
            lock_q <= 1'b1;
        end else if (unlock_hit) begin
            lock_q <= 1'b0;
        end
    end

    // ==========================================================
    // Register writes and staged commit.
    assign crc_bad = last_bit && phase_q == PH_CRC && !rd_q
                     && byte_w != crc_q;
    assign wr_fire = !lock_q && !rd_q && !unlock_hit && last_bit
                     && ((phase_q == PH_DATA && !crc_on)
                     || (phase_q == PH_CRC && byte_w == crc_q));
    assign wr_data = crc_on ? pdata_q : byte_w;
    assign in_stage = addr_q >= `SRA_STAGE_LO && addr_q <= `SRA_STAGE_HI;

    always_ff @(posedge i_sclk) begin
        if (srst) begin
            for (int i = 0; i < `SRA_REG_NUM; i++) begin
                regs_q[i] <= 8'h00;
            end
            regs_q[`SRA_REG_IFCFG] <= `SRA_IFCFG_RST;
            for (int i = 0; i < `SRA_STAGE_N; i++) begin
                shadow_q[i] <= 8'h00;
            end
        end else if (wr_fire && !i_cs_n) begin
            if (in_stage) begin
                shadow_q[3'(addr_q - `SRA_STAGE_LO)] <= wr_data;
            end else if (addr_q == `SRA_REG_XFER) begin
                if (wr_data[`SRA_XFER_BIT]) begin
                    for (int i = 0; i < `SRA_STAGE_N; i++) begin
                        regs_q[`SRA_STAGE_LO + i] <= shadow_q[i];
                    end
                end
            end else begin
                regs_q[addr_q] <= wr_data;
            end
        end
    end

    always_ff @(posedge i_sclk) begin
        if (srst) begin
            commit_tgl_q <= 1'b0;
            err_tgl_q <= 1'b0;
        end else if (!i_cs_n) begin
            if (wr_fire && addr_q == `SRA_REG_XFER
                && wr_data[`SRA_XFER_BIT]) begin
                commit_tgl_q <= !commit_tgl_q;
            end
            if (crc_bad) begin
                err_tgl_q <= !err_tgl_q;
            end
        end
    end

    // ==========================================================
    // Output drive on the falling edge.
    logic out_q, drv_q;

    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            out_q <= 1'b0;
            drv_q <= 1'b0;
        end else begin
            out_q <= tx_q[~bit_q];
            drv_q <= sel && rd_q && phase_q != PH_CMD;
        end
    end

    assign o_sdo = out_q;
    assign o_sdi_out = out_q;
    assign o_sdo_oe = drv_q && !tw && !iso;
    assign o_sdi_oe = drv_q && (tw || iso);

    // ==========================================================
    // Checks.
    a_port_inactive: assert property (@(posedge i_sclk)
        disable iff (srst || i_cs_n)
        !sel ##1 !sel |-> !o_sdo_oe && !o_sdi_oe)
        else $error("port drives while deselected");

    a_three_wire: assert property (@(posedge i_sclk)
        disable iff (srst || i_cs_n)
        (tw || iso) |-> !o_sdo_oe)
        else $error("output pin driven in 3-wire mode");

    a_crc_seed: assert property (@(posedge i_sclk)
        disable iff (srst || i_cs_n)
        phase_q == PH_CMD && bit_q == 3'h0 |-> crc_q == `SRA_CRC_SEED)
        else $error("CRC not seeded at instruction");

    a_lock_set: assert property (@(posedge i_sclk)
        disable iff (srst || i_cs_n)
        lock_hit |=> lock_q && ones_q == 5'h00)
        else $error("lock not entered");

    a_unlock_reset: assert property (@(posedge i_sclk)
        disable iff (srst || i_cs_n)
        unlock_hit |=> !lock_q && phase_q == PH_CMD && bit_q == 3'h0)
        else $error("unlock did not reset port");

    a_locked_write: assert property (@(posedge i_sclk)
        disable iff (srst || i_cs_n)
        lock_q |-> !wr_fire)
        else $error("write while locked");

    a_single_transaction_flag: assert property (@(posedge i_sclk)
        disable iff (srst || i_cs_n)
        last_bit && phase_q == PH_DATA && single && !crc_on
        |=> phase_q == PH_CMD)
        else $error("single mode kept streaming");

    logic [4:0] pkt_q;
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            pkt_q <= 5'h00;
        end else if (srst || unlock_hit || !iso) begin
            pkt_q <= 5'h00;
        end else if (sel) begin
            pkt_q <= (pkt_q == `SRA_PKT_LAST) ? 5'h00 : 5'(pkt_q + 5'h01);
        end
    end

    a_iso_packet: assert property (@(posedge i_sclk)
        disable iff (srst || i_cs_n)
        iso && sel && pkt_q == `SRA_PKT_LAST |=> phase_q == PH_CMD)
        else $error("isolated packet not 24 bits");

    a_stream_wrap: assert property (@(posedge i_sclk)
        disable iff (srst || i_cs_n)
        last_bit && phase_q == PH_DATA && !crc_on && stream_on && wrap
        && !unlock_hit |=> addr_q == $past(base_q) && cnt_q == 8'h00)
        else $error("stream did not wrap");

    a_commit: assert property (@(posedge i_sclk)
        disable iff (srst || i_cs_n)
        wr_fire && addr_q == `SRA_REG_XFER && wr_data[`SRA_XFER_BIT]
        |=> regs_q[`SRA_STAGE_LO] == $past(shadow_q[0])
        && regs_q[`SRA_REG_XFER] == 8'h00)
        else $error("staged commit failed");

endmodule

/* File: verif/sra_host_model.sv */
/* Behavioural serial host that drives the register access port in mode 0.
   Assumes the bench resolves the shared data wire and returns it on i_rx. */
`timescale 1ns/1ps

module sra_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    output logic o_sdi_oe,
    input wire logic i_rx
);
    // Chip select starts low because the isolated mode needs it grounded.
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b0;
        o_sdi = 1'b0;
        o_sdi_oe = 1'b1;
    end

    task automatic pulses(input int n);
        repeat (n) begin
            #15 o_sclk = 1'b1;
            #15 o_sclk = 1'b0;
        end
    endtask

    // The host releases the data line after the command byte of a read.
    task automatic xfer(input int n, input logic [31:0] tx, input logic rd,
                        input logic endcs, output logic [31:0] rx);
        rx = '0;
        o_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_sdi_oe = !(rd && i < n - 8);
            o_sdi = tx[i];
            #15 o_sclk = 1'b1;
            rx[i] = i_rx;
            #15 o_sclk = 1'b0;
        end
        o_sdi_oe = 1'b1;
        if (endcs) begin
            #15 o_cs_n = 1'b1;
            #30;
        end
    endtask
endmodule

/* File: verif/tb_top.sv */
/* Self-checking bench of the serial register access port.
   Assumes the design and the host model are compiled before it. */
`timescale 1ns/1ps

module tb_top;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_spi_sel = 1'b1;
    logic i_three_wire = 1'b0;
    logic i_crc_en = 1'b0;
    logic sclk, cs_n, h_sdi, h_oe, sdi_line, sdo_line, rx_line;
    logic o_sdo, o_sdo_oe, o_sdi_out, o_sdi_oe;
    logic o_locked, o_isolated, o_commit, o_crc_err;
    int miscompares = 0;
    int n_checks = 0;
    int seed = 92;
    int n_err = 0;
    int n_com = 0;
    int n_bad_oe = 0;
    logic [31:0] rx;
    logic [7:0] d;
    logic [7:0] v;
    logic [6:0] a;
    logic iso = 1'b1;

    // A released wire shows the inverse of its last level.
    assign sdi_line = o_sdi_oe ? o_sdi_out : (h_oe ? h_sdi : ~h_sdi);
    assign sdo_line = o_sdo_oe ? o_sdo : ~o_sdo;
    assign rx_line = (i_three_wire || iso) ? sdi_line : sdo_line;

    initial forever #2.5 i_ref_clk = ~i_ref_clk;

    sra_top sra_top_inst (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_sdi(sdi_line), .i_spi_sel(i_spi_sel),
        .i_three_wire(i_three_wire), .i_crc_en(i_crc_en),
        .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_sdi_out(o_sdi_out),
        .o_sdi_oe(o_sdi_oe), .o_locked(o_locked),
        .o_isolated(o_isolated), .o_commit(o_commit),
        .o_crc_err(o_crc_err)
    );

    sra_host_model sra_host_model_inst (
        .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(h_sdi), .o_sdi_oe(h_oe),
        .i_rx(rx_line)
    );

    // ==========================================================
    // Monitors
    always @(posedge i_ref_clk) begin
        n_err <= n_err + int'(o_crc_err === 1'b1);
        n_com <= n_com + int'(o_commit === 1'b1);
    end

    always @(posedge sclk) begin
        if (i_rst_n && (i_three_wire || iso) && o_sdo_oe !== 1'b0)
            n_bad_oe++;
    end

    // ==========================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [7:0] crc8(input logic [15:0] x);
        logic [7:0] c;
        c = 8'ha5;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ x[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    task automatic wr(input logic [6:0] ad, input logic [7:0] dt,
                      input logic c);
        logic [31:0] r;
        if (c)
            sra_host_model_inst.xfer(24,
                32'({1'b0, ad, dt, crc8({1'b0, ad, dt})}), 1'b0, !iso, r);
        else
            sra_host_model_inst.xfer(16, 32'({1'b0, ad, dt}), 1'b0, 1'b1, r);
    endtask

    task automatic rd(input logic [6:0] ad, input logic c,
                      output logic [7:0] dt);
        logic [31:0] r;
        sra_host_model_inst.xfer(c ? 24 : 16,
            32'({1'b1, ad}) << (c ? 16 : 8), 1'b1, !iso, r);
        dt = c ? r[15:8] : r[7:0];
        if (c)
            check(r[7:0], crc8({1'b1, ad, dt}), "read crc");
    endtask

    // Keeps the serial clock edges off the reference clock edges.
    task automatic resync;
        #1.3;
        sra_host_model_inst.pulses(3);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        $display("ERROR %0t watchdog expired", $time);
        final_report;
    end

    // ==========================================================
    // Main sequence
    initial begin
        fork
            repeat (8) @(posedge i_ref_clk);
            sra_host_model_inst.pulses(4);
        join
        @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        // Chip select must stay low here, so two edges only: the third
        // edge already takes the first bit of the first packet.
        #1.3;
        sra_host_model_inst.pulses(2);
        check(o_isolated, 1'b1, "isolated at start");
        check(o_locked, 1'b0, "unlocked at start");
        wr(7'h10, 8'h5a, 1'b1);
        rd(7'h10, 1'b1, d);
        check(d, 8'h5a, "isolated read");
        sra_host_model_inst.xfer(24, 32'({16'h1033, ~crc8(16'h1033)}),
            1'b0, 1'b1, rx);
        iso = 1'b0;
        check(n_err, 1, "crc error pulse");
        check(o_isolated, 1'b0, "isolated left");
        rd(7'h10, 1'b0, d);
        check(d, 8'h5a, "bad crc write dropped");
        $display("test isolated done");

        @(posedge i_ref_clk);
        i_spi_sel <= 1'b0;
        resync;
        wr(7'h10, 8'h99, 1'b0);
        @(posedge i_ref_clk);
        i_spi_sel <= 1'b1;
        resync;
        rd(7'h10, 1'b0, d);
        check(d, 8'h5a, "port disabled");
        $display("test select done");

        for (int k = 0; k < 8; k++) begin
            @(posedge i_ref_clk);
            i_three_wire <= 1'($random(seed));
            i_crc_en <= 1'($random(seed));
            resync;
            a = 7'h11 + 7'($random(seed) & 15);
            v = 8'($random(seed));
            wr(a, v, i_crc_en);
            rd(a, i_crc_en, d);
            check(d, v, "write then read");
        end
        @(posedge i_ref_clk);
        i_three_wire <= 1'b0;
        i_crc_en <= 1'b0;
        resync;
        $display("test random done");

        sra_host_model_inst.xfer(32, 32'h12c3_8000, 1'b0, 1'b1, rx);
        check(rx[7:0], 8'h01, "flag reset value");
        rd(7'h12, 1'b0, d);
        check(d, 8'hc3, "single write");
        wr(7'h00, 8'h00, 1'b0);
        wr(7'h0e, 8'h02, 1'b0);
        sra_host_model_inst.xfer(32, 32'h1001_0203, 1'b0, 1'b1, rx);
        rd(7'h10, 1'b0, d);
        check(d, 8'h03, "stream wrap");
        rd(7'h11, 1'b0, d);
        check(d, 8'h02, "stream second");
        wr(7'h00, 8'h01, 1'b0);
        wr(7'h0e, 8'h00, 1'b0);
        $display("test stream done");

        wr(7'h30, 8'h77, 1'b0);
        wr(7'h0f, 8'h01, 1'b0);
        check(n_com, 1, "commit pulse");
        rd(7'h0f, 1'b0, d);
        check(d, 8'h00, "commit self clear");
        rd(7'h30, 1'b0, d);
        check(d, 8'h77, "staged value");
        $display("test commit done");

        sra_host_model_inst.xfer(24, 32'h00ff_ffff, 1'b0, 1'b1, rx);
        check(o_locked, 1'b1, "locked");
        wr(7'h10, 8'h44, 1'b0);
        rd(7'h10, 1'b0, d);
        check(d, 8'h00, "locked read");
        sra_host_model_inst.xfer(24, 32'h00ff_fffe, 1'b0, 1'b1, rx);
        check(o_locked, 1'b0, "unlocked");
        rd(7'h10, 1'b0, d);
        check(d, 8'h03, "locked write dropped");
        check(n_bad_oe, 0, "output pin idle");
        $display("test lock done");
        final_report;
    end
endmodule
